//--- common/ntrc_pkg.sv
// Purpose: Shared constants and calendar helpers for the timekeeping RAM
// Assumes: 200 MHz system clock, packed BCD time bytes
// Notes: Clock byte slots are indexed 0..7 from the lowest top address

package ntrc_pkg;

	// Memory shape
	localparam int ADDR_W = 13;
	localparam int DATA_W = 8;
	localparam int MEM_DEPTH = 8192;
	localparam logic [12:0] CLK_BASE = 13'h1ff8;

	// Clock byte slots
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_SEC = 3'h1;
	localparam logic [2:0] IDX_MIN = 3'h2;
	localparam logic [2:0] IDX_HOUR = 3'h3;
	localparam logic [2:0] IDX_DAY = 3'h4;
	localparam logic [2:0] IDX_DATE = 3'h5;
	localparam logic [2:0] IDX_MONTH = 3'h6;
	localparam logic [2:0] IDX_YEAR = 3'h7;

	// Control bit positions
	localparam int CTRL_SET_BIT = 7;
	localparam int CTRL_FREEZE_BIT = 6;
	localparam int SEC_HALT_BIT = 7;
	localparam int DAY_FREQ_BIT = 6;

	// Timekeeping fields per slot; other bits are storage or control bits
	localparam logic [7:0][7:0] TIME_MASK = {8'hff, 8'h1f, 8'h3f, 8'h07, 8'h3f, 8'h7f, 8'h7f, 8'h00};
	localparam logic [7:0][7:0] VIS_RESET = {8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

	// BCD roll points
	localparam logic [7:0] SEC_LAST = 8'h59;
	localparam logic [7:0] HOUR_LAST = 8'h23;
	localparam logic [7:0] DAY_LAST = 8'h07;
	localparam logic [7:0] MONTH_LAST = 8'h12;
	localparam logic [7:0] YEAR_LAST = 8'h99;
	localparam logic [7:0] FIRST_ONE = 8'h01;

	// Timing: half period of the 512 Hz test toggle
	localparam int CLK_PERIOD_NS = 5;
	localparam int HALF_TOGGLE_NS = 976562;
	localparam int HALF_TOGGLE_CYCLES = HALF_TOGGLE_NS / CLK_PERIOD_NS;
	localparam logic [9:0] TOGGLES_LAST = 10'h3ff;

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		return (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
	endfunction

	function automatic logic is_leap(input logic [7:0] y);
		if (y[4]) begin
			return (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
		end
		return (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
	endfunction

	function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
		case (m)
			8'h02: return is_leap(y) ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: return 8'h30;
			default: return 8'h31;
		endcase
	endfunction

endpackage

//--- common/ntrc_time_if.sv
// Purpose: Carries counter time and load requests between top and counter
// Assumes: Single system clock
// Notes: Slot 0 of now_val is unused and reads zero; slot 0 of set_val carries the control byte

`timescale 1ns/1ps

interface ntrc_time_if;
	logic tick;
	logic load;
	logic [7:0][7:0] set_val;
	logic [7:0][7:0] now_val;

	modport cnt (input tick, input load, input set_val, output now_val);
	modport ctl (output tick, output load, output set_val, input now_val);
endinterface

//--- verilog/ntrc_ram.sv
// Purpose: Byte-wide static storage behind the host pins
// Assumes: One write or read per clock
// Notes: Read data comes out of a register, one cycle behind the address

`timescale 1ns/1ps

module ntrc_ram (
	// Clock
	input wire logic i_clk_sys,
	// Access
	input wire logic i_we,
	input wire logic [12:0] i_addr,
	input wire logic [7:0] i_wdata,
	output logic [7:0] o_rdata
);

	logic [7:0] mem [0:ntrc_pkg::MEM_DEPTH-1];

	always_ff @(posedge i_clk_sys) begin
		if (i_we) begin
			mem[i_addr] <= i_wdata;
		end
		o_rdata <= mem[i_addr];
	end

endmodule

//--- verilog/ntrc_count.sv
// Purpose: Internal BCD calendar counters
// Assumes: tick is a one-cycle pulse once per second
// Notes: Load has priority over a tick in the same cycle

`timescale 1ns/1ps

module ntrc_count (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// Time link
	ntrc_time_if.cnt cif
);

	logic [7:0][7:0] now;
	logic [7:0][7:0] next_now;
	logic day_carry;

	always_comb begin
		next_now = now;
		day_carry = 1'b0;
		if (cif.load) begin
			for (int i = 0; i < 8; i++) begin
				next_now[i] = cif.set_val[i] & ntrc_pkg::TIME_MASK[i];
			end
		end else if (cif.tick) begin
			if (now[ntrc_pkg::IDX_SEC] != ntrc_pkg::SEC_LAST) begin
				next_now[ntrc_pkg::IDX_SEC] = ntrc_pkg::bcd_inc(now[ntrc_pkg::IDX_SEC]);
			end else begin
				next_now[ntrc_pkg::IDX_SEC] = 8'h00;
				if (now[ntrc_pkg::IDX_MIN] != ntrc_pkg::SEC_LAST) begin
					next_now[ntrc_pkg::IDX_MIN] = ntrc_pkg::bcd_inc(now[ntrc_pkg::IDX_MIN]);
				end else begin
					next_now[ntrc_pkg::IDX_MIN] = 8'h00;
					if (now[ntrc_pkg::IDX_HOUR] != ntrc_pkg::HOUR_LAST) begin
						next_now[ntrc_pkg::IDX_HOUR] = ntrc_pkg::bcd_inc(now[ntrc_pkg::IDX_HOUR]);
					end else begin
						next_now[ntrc_pkg::IDX_HOUR] = 8'h00;
						day_carry = 1'b1;
					end
				end
			end
			if (day_carry) begin
				next_now[ntrc_pkg::IDX_DAY] = (now[ntrc_pkg::IDX_DAY] == ntrc_pkg::DAY_LAST) ?
					ntrc_pkg::FIRST_ONE : ntrc_pkg::bcd_inc(now[ntrc_pkg::IDX_DAY]);
				if (now[ntrc_pkg::IDX_DATE] !=
					ntrc_pkg::month_end(now[ntrc_pkg::IDX_MONTH], now[ntrc_pkg::IDX_YEAR])) begin
					next_now[ntrc_pkg::IDX_DATE] = ntrc_pkg::bcd_inc(now[ntrc_pkg::IDX_DATE]);
				end else begin
					next_now[ntrc_pkg::IDX_DATE] = ntrc_pkg::FIRST_ONE;
					if (now[ntrc_pkg::IDX_MONTH] != ntrc_pkg::MONTH_LAST) begin
						next_now[ntrc_pkg::IDX_MONTH] = ntrc_pkg::bcd_inc(now[ntrc_pkg::IDX_MONTH]);
					end else begin
						next_now[ntrc_pkg::IDX_MONTH] = ntrc_pkg::FIRST_ONE;
						next_now[ntrc_pkg::IDX_YEAR] = (now[ntrc_pkg::IDX_YEAR] == ntrc_pkg::YEAR_LAST) ?
							8'h00 : ntrc_pkg::bcd_inc(now[ntrc_pkg::IDX_YEAR]);
					end
				end
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			now <= ntrc_pkg::VIS_RESET;
		end else begin
			now <= next_now;
		end
	end

	assign cif.now_val = now;

	////////////////////////////////////////////////////////////////////////

	AST_SEC_WRAP: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(cif.tick && !cif.load && now[ntrc_pkg::IDX_SEC] == 8'h59 && now[ntrc_pkg::IDX_MIN] == 8'h59)
		|=> now[ntrc_pkg::IDX_SEC] == 8'h00 && now[ntrc_pkg::IDX_MIN] == 8'h00)
		else $error("seconds did not carry into minutes");

	AST_LEAP_DAY: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		(day_carry && !cif.load && now[ntrc_pkg::IDX_MONTH] == 8'h02 && now[ntrc_pkg::IDX_DATE] == 8'h28)
		|=> now[ntrc_pkg::IDX_DATE] == (ntrc_pkg::is_leap($past(now[ntrc_pkg::IDX_YEAR])) ? 8'h29 : 8'h01))
		else $error("february end handled wrongly");

	COV_MONTH_ROLL: cover property (@(posedge i_clk_sys) disable iff (!i_reset_n)
		day_carry && now[ntrc_pkg::IDX_DATE] == 8'h31);

endmodule

//--- verilog/ntrc_top.sv
// Purpose: Byte-wide memory with calendar clock in the top eight bytes
// Assumes: Host pins are asynchronous; supply fail is a level flag
// Notes: Read data and enable appear five clock edges after the pins
//
// What this block does
// - 8192 bytes, thirteen address, eight data lines
// - Clock bytes sit at top eight addresses
// - Calendar kept as packed BCD, 24-hour
// - Month lengths and leap years through 2099
// - Visible bytes kept apart from running counters
// - Supply fail ignores access, floats data
// - Deselected chip floats data, no access
// - Write enable low stores byte, any OE
// - Output enable low reads addressed byte
// - Both enables high: selected, data floats
// - Freeze bit stops updates while set
// - Frozen bytes hold time; counters keep running
// - Freeze cleared refreshes all within second
// - Set bit halts updates for loading
// - Set bit cleared loads counters, resumes
// - Seconds top bit halts the oscillator
// - Frequency check toggles seconds bit zero 512Hz
// - Held seconds read shows toggle live
// - Unused clock bits are plain storage

`timescale 1ns/1ps

module ntrc_top #(
	parameter logic [17:0] P_HALF_CYCLES = 18'(ntrc_pkg::HALF_TOGGLE_CYCLES)
) (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_reset_n,
	// Host pins
	input wire logic i_select_low_n,
	input wire logic i_select_high,
	input wire logic i_out_en_n,
	input wire logic i_write_en_n,
	input wire logic [12:0] i_location_lines,
	input wire logic [7:0] i_byte_lines,
	output logic [7:0] o_byte_lines,
	output logic o_byte_lines_oe,
	// Supply monitor
	input wire logic i_supply_fail
);

	typedef enum logic [2:0] {ST_IDLE, ST_SELECT, ST_READ, ST_WRITE, ST_OFF} ntrc_acc_type;

	ntrc_time_if tif ();

	////////////////////////////////////////////////////////////////////////
	// Pin synchroniser

	logic [25:0] pin_meta;
	logic [25:0] pin_sync;

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			pin_meta <= 26'h0;
			pin_sync <= 26'h0;
		end else begin
			pin_meta <= {i_supply_fail, i_select_low_n, i_select_high, i_out_en_n, i_write_en_n,
				i_location_lines, i_byte_lines};
			pin_sync <= pin_meta;
		end
	end

	logic pf_s;
	logic sel_s;
	logic oe_s;
	logic wr_s;

	assign pf_s = pin_sync[25];
	assign sel_s = !pin_sync[24] && pin_sync[23];
	assign oe_s = !pin_sync[22];
	assign wr_s = !pin_sync[21];

	////////////////////////////////////////////////////////////////////////
	// Access state

	ntrc_acc_type state;
	ntrc_acc_type next_state;
	logic [12:0] acc_addr;
	logic [12:0] next_acc_addr;
	logic [7:0] acc_data;
	logic [7:0] next_acc_data;

	always_comb begin
		next_acc_addr = pin_sync[20:8];
		next_acc_data = pin_sync[7:0];
		if (pf_s) begin
			next_state = ST_OFF;
		end else if (!sel_s) begin
			next_state = ST_IDLE;
		end else if (wr_s) begin
			next_state = ST_WRITE;
		end else if (oe_s) begin
			next_state = ST_READ;
		end else begin
			next_state = ST_SELECT;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			state <= ST_IDLE;
			acc_addr <= 13'h0;
			acc_data <= 8'h0;
		end else begin
			state <= next_state;
			acc_addr <= next_acc_addr;
			acc_data <= next_acc_data;
		end
	end

	logic clk_hit;
	logic [2:0] acc_idx;
	logic wr_clk;
	logic ram_we;
	logic [7:0] ram_rdata;

	// Top eight locations go to the clock bytes, never the array
	assign clk_hit = acc_addr[12:3] == ntrc_pkg::CLK_BASE[12:3];
	assign acc_idx = acc_addr[2:0];
	assign wr_clk = (state == ST_WRITE) && clk_hit;
	assign ram_we = (state == ST_WRITE) && !clk_hit;

	ntrc_ram u_ram (
		.i_clk_sys(i_clk_sys),
		.i_we(ram_we),
		.i_addr(acc_addr),
		.i_wdata(acc_data),
		.o_rdata(ram_rdata)
	);

	////////////////////////////////////////////////////////////////////////
	// Oscillator divider

	logic [17:0] div_cnt;
	logic [17:0] next_div;
	logic [9:0] tog_cnt;
	logic [9:0] next_tog_cnt;
	logic toggle;
	logic next_toggle;
	logic tick;
	logic next_tick;
	logic osc_run;

	always_comb begin
		next_div = div_cnt;
		next_tog_cnt = tog_cnt;
		next_toggle = toggle;
		next_tick = 1'b0;
		if (osc_run) begin
			if (div_cnt == P_HALF_CYCLES - 18'h1) begin
				next_div = 18'h0;
				next_toggle = !toggle;
				next_tog_cnt = tog_cnt + 10'h1;
				next_tick = tog_cnt == ntrc_pkg::TOGGLES_LAST;
			end else begin
				next_div = div_cnt + 18'h1;
			end
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			div_cnt <= 18'h0;
			tog_cnt <= 10'h0;
			toggle <= 1'b0;
			tick <= 1'b0;
		end else begin
			div_cnt <= next_div;
			tog_cnt <= next_tog_cnt;
			toggle <= next_toggle;
			tick <= next_tick;
		end
	end

	assign tif.tick = tick;

	////////////////////////////////////////////////////////////////////////
	// Visible clock bytes

	logic [7:0][7:0] vis;
	logic [7:0][7:0] next_vis;
	logic set_q;
	logic next_set_q;
	logic frozen;

	assign frozen = vis[ntrc_pkg::IDX_CTRL][ntrc_pkg::CTRL_SET_BIT] ||
		vis[ntrc_pkg::IDX_CTRL][ntrc_pkg::CTRL_FREEZE_BIT];
	assign osc_run = !vis[ntrc_pkg::IDX_SEC][ntrc_pkg::SEC_HALT_BIT];

	always_comb begin
		next_vis = vis;
		next_set_q = vis[ntrc_pkg::IDX_CTRL][ntrc_pkg::CTRL_SET_BIT];
		// Copy every cycle while free, so a clear refreshes at once
		if (!frozen) begin
			for (int i = 1; i < 8; i++) begin
				next_vis[i] = (vis[i] & ~ntrc_pkg::TIME_MASK[i]) |
					(tif.now_val[i] & ntrc_pkg::TIME_MASK[i]);
			end
		end
		// Host write wins over the copy; storage bits kept whole
		if (wr_clk) begin
			next_vis[acc_idx] = acc_data;
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			vis <= ntrc_pkg::VIS_RESET;
			set_q <= 1'b0;
		end else begin
			vis <= next_vis;
			set_q <= next_set_q;
		end
	end

	assign tif.load = set_q && !vis[ntrc_pkg::IDX_CTRL][ntrc_pkg::CTRL_SET_BIT];
	assign tif.set_val = vis;

	ntrc_count u_count (
		.i_clk_sys(i_clk_sys),
		.i_reset_n(i_reset_n),
		.cif(tif)
	);

	////////////////////////////////////////////////////////////////////////
	// Read path

	logic rd_q;
	logic next_rd_q;
	logic hit_q;
	logic next_hit_q;
	logic [2:0] idx_q;
	logic [2:0] next_idx_q;
	logic ft_on;
	logic [7:0] clk_byte;
	logic [7:0] next_out;

	assign ft_on = vis[ntrc_pkg::IDX_DAY][ntrc_pkg::DAY_FREQ_BIT] && osc_run;

	always_comb begin
		next_rd_q = state == ST_READ;
		next_hit_q = clk_hit;
		next_idx_q = acc_idx;
		clk_byte = vis[idx_q];
		// Live toggle, so a long held read follows it
		if (idx_q == ntrc_pkg::IDX_SEC && ft_on) begin
			clk_byte[0] = toggle;
		end
		next_out = hit_q ? clk_byte : ram_rdata;
	end

	always_ff @(posedge i_clk_sys) begin
		if (!i_reset_n) begin
			rd_q <= 1'b0;
			hit_q <= 1'b0;
			idx_q <= 3'h0;
			o_byte_lines <= 8'h0;
			o_byte_lines_oe <= 1'b0;
		end else begin
			rd_q <= next_rd_q;
			hit_q <= next_hit_q;
			idx_q <= next_idx_q;
			o_byte_lines <= next_out;
			o_byte_lines_oe <= rd_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_reset_n);

	AST_FAIL_FLOAT: assert property (pf_s |-> ##3 !o_byte_lines_oe)
		else $error("data driven during supply fail");

	AST_DESELECT_FLOAT: assert property ((!sel_s && !pf_s) |=> state == ST_IDLE ##2 !o_byte_lines_oe)
		else $error("data driven while deselected");

	AST_CLK_WRITE: assert property (wr_clk |=> vis[$past(acc_idx)] == $past(acc_data))
		else $error("clock byte write lost");

	AST_READ_DRIVE: assert property ((sel_s && !pf_s && !wr_s && oe_s) |-> ##3 o_byte_lines_oe)
		else $error("read did not drive data");

	AST_IDLE_SELECT: assert property ((sel_s && !pf_s && !wr_s && !oe_s) |-> ##3 !o_byte_lines_oe)
		else $error("data driven with both enables high");

	AST_FREEZE_HOLD: assert property ((vis[ntrc_pkg::IDX_CTRL][ntrc_pkg::CTRL_FREEZE_BIT] && !wr_clk)
		|=> vis[ntrc_pkg::IDX_MIN] == $past(vis[ntrc_pkg::IDX_MIN]))
		else $error("frozen minutes changed");

	AST_SET_HOLD: assert property ((vis[ntrc_pkg::IDX_CTRL][ntrc_pkg::CTRL_SET_BIT] && !wr_clk)
		|=> vis[ntrc_pkg::IDX_SEC][6:0] == $past(vis[ntrc_pkg::IDX_SEC][6:0]))
		else $error("seconds changed while setting");

	AST_REFRESH: assert property ((!frozen && !wr_clk)
		|=> vis[ntrc_pkg::IDX_MIN][6:0] == $past(tif.now_val[ntrc_pkg::IDX_MIN][6:0]))
		else $error("visible minutes not refreshed");

	AST_SET_LOAD: assert property ($fell(vis[ntrc_pkg::IDX_CTRL][ntrc_pkg::CTRL_SET_BIT])
		|=> tif.now_val[ntrc_pkg::IDX_MIN] == {1'b0, $past(vis[ntrc_pkg::IDX_MIN][6:0])})
		else $error("set values not loaded");

	AST_OSC_HALT: assert property (!osc_run |=> !tick && toggle == $past(toggle))
		else $error("oscillator ran while halted");

	AST_TOGGLE_RATE: assert property ((osc_run && div_cnt == P_HALF_CYCLES - 18'h1)
		|=> toggle != $past(toggle))
		else $error("test toggle missed");

	AST_FREQ_PIN: assert property ((hit_q && idx_q == ntrc_pkg::IDX_SEC && ft_on)
		|=> o_byte_lines[0] == $past(toggle))
		else $error("data line zero not following toggle");

	COV_FREEZE: cover property ($rose(vis[ntrc_pkg::IDX_CTRL][ntrc_pkg::CTRL_FREEZE_BIT]));
	COV_SET_LOAD: cover property (tif.load);
	COV_FT_READ: cover property (rd_q && hit_q && idx_q == ntrc_pkg::IDX_SEC && ft_on);

endmodule

//--- bench/ntrc_host_model.sv
// Purpose: Host side of the byte-wide memory pins
// Assumes: Pins change only just after a rising edge
// Notes: Chip data is taken at every edge where its enable is high

`timescale 1ns/1ps

module ntrc_host_model (
	// Clock
	input wire logic i_clk_sys,
	// Chip side of the data wire
	input wire logic [7:0] i_byte_lines,
	input wire logic i_byte_lines_oe,
	// Host pins
	output logic o_select_low_n,
	output logic o_select_high,
	output logic o_out_en_n,
	output logic o_write_en_n,
	output logic [12:0] o_location_lines,
	output logic [7:0] o_byte_lines,
	output logic o_byte_lines_oe
);
	initial begin
		o_select_low_n = 1'b1;
		o_select_high = 1'b0;
		o_out_en_n = 1'b1;
		o_write_en_n = 1'b1;
		o_location_lines = 13'h0000;
		o_byte_lines = 8'h00;
		o_byte_lines_oe = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// Selects and data drive outlive the enables by three edges; address stays until the next drive
	task automatic release_pins();
		o_write_en_n <= 1'b1;
		o_out_en_n <= 1'b1;
		repeat (3) @(posedge i_clk_sys);
		o_select_low_n <= 1'b1;
		o_select_high <= 1'b0;
		o_byte_lines_oe <= 1'b0;
		repeat (6) @(posedge i_clk_sys);
	endtask

	task automatic drive(input logic [1:0] sel, input logic we_n, input logic oe_n, input logic [12:0] a,
		input logic [7:0] d);
		@(posedge i_clk_sys);
		o_select_low_n <= sel[0];
		o_select_high <= sel[1];
		o_write_en_n <= we_n;
		o_out_en_n <= oe_n;
		o_location_lines <= a;
		o_byte_lines <= d;
		o_byte_lines_oe <= ~we_n;
	endtask

	////////////////////////////////////////////////////////////////
	// Pins stand eight edges, three more than the five-edge answer lag
	task automatic access(input logic [1:0] sel, input logic we_n, input logic oe_n, input logic [12:0] a,
		input logic [7:0] d, output logic [7:0] q, output logic seen);
		q = 8'h00;
		seen = 1'b0;
		drive(sel, we_n, oe_n, a, d);
		// Sample 1 ns after the edge, once the chip outputs have settled
		repeat (8) begin
			@(posedge i_clk_sys);
			#1;
			if (i_byte_lines_oe === 1'b1) begin
				q = i_byte_lines;
				seen = 1'b1;
			end
		end
		release_pins();
	endtask

	// Sustained read; counts changes of data line zero over 32 edges
	task automatic hold_read(input logic [12:0] a, output int flips);
		logic prev;
		flips = 0;
		drive(2'b10, 1'b1, 1'b0, a, 8'h00);
		repeat (8) @(posedge i_clk_sys);
		#1;
		prev = i_byte_lines[0];
		repeat (32) begin
			@(posedge i_clk_sys);
			#1;
			if (i_byte_lines[0] !== prev) begin
				flips++;
			end
			prev = i_byte_lines[0];
		end
		release_pins();
	endtask
endmodule

//--- bench/ntrc_top_tb_top.sv
// Purpose: Self-checking bench for the timekeeping memory
// Assumes: Short toggle period, so one second is 4096 clocks
// Notes: Tick phase is unknown, so seconds are judged to within one tick

`timescale 1ns/1ps

module ntrc_top_tb_top;
	localparam logic [17:0] HALF = 18'h00004;
	localparam logic [63:0] RST_IMG = 64'h0001010100000000;
	localparam logic [47:0] CAL [5] = '{48'h000228000229, 48'h010228010301, 48'h960229960301,
		48'h000430000501, 48'h991231000101};
	logic i_clk_sys;
	logic i_reset_n;
	logic i_supply_fail;
	logic sel_low_n;
	logic sel_high;
	logic oe_n;
	logic we_n;
	logic [12:0] loc;
	logic [7:0] host_d;
	logic host_en;
	logic [7:0] chip_d;
	logic chip_en;
	logic [7:0] last_q = 8'h00;
	logic [7:0] wire_d;
	logic [7:0] q;
	logic [7:0] s0;
	logic [47:0] expv;
	logic seen;
	int flips;
	int mismatches = 0;
	int samples_checked = 0;

	// Released wire shows the inverse of its last level
	assign wire_d = chip_en ? chip_d : (host_en ? host_d : ~last_q);
	always @(posedge i_clk_sys) last_q <= wire_d;

	initial begin
		i_clk_sys = 1'b0;
		forever #2.5 i_clk_sys = ~i_clk_sys;
	end

	ntrc_top #(.P_HALF_CYCLES(HALF)) dut_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
		.i_select_low_n(sel_low_n), .i_select_high(sel_high), .i_out_en_n(oe_n), .i_write_en_n(we_n),
		.i_location_lines(loc), .i_byte_lines(wire_d), .o_byte_lines(chip_d), .o_byte_lines_oe(chip_en),
		.i_supply_fail(i_supply_fail));

	ntrc_host_model host_u (.i_clk_sys(i_clk_sys), .i_byte_lines(wire_d), .i_byte_lines_oe(chip_en),
		.o_select_low_n(sel_low_n), .o_select_high(sel_high), .o_out_en_n(oe_n), .o_write_en_n(we_n),
		.o_location_lines(loc), .o_byte_lines(host_d), .o_byte_lines_oe(host_en));

	////////////////////////////////////////////////////////////////
	task automatic final_report();
		if (mismatches == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic wr(input logic [12:0] a, input logic [7:0] d);
		host_u.access(2'b10, 1'b0, 1'b1, a, d, q, seen);
	endtask

	task automatic rd(input logic [12:0] a, input logic [7:0] exp);
		host_u.access(2'b10, 1'b1, 1'b0, a, 8'h00, q, seen);
		check("drive", {7'h00, seen}, 8'h01);
		check("byte", q, exp);
	endtask

	// Access that must leave the data lines floating
	task automatic quiet(input logic [1:0] sel, input logic we_n, input logic oe_n);
		host_u.access(sel, we_n, oe_n, 13'h0000, 8'hff, q, seen);
		check("float", {7'h00, seen}, 8'h00);
	endtask

	task automatic set_time(input logic [55:0] t);
		wr(13'h1ff8, 8'h80);
		for (int i = 0; i < 7; i++) begin
			wr(13'h1ff9 + 13'(i), t[8*i +: 8]);
		end
		wr(13'h1ff8, 8'h00);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		repeat (100000) @(posedge i_clk_sys);
		mismatches++;
		final_report();
	end

	initial begin
		i_reset_n = 1'b0;
		i_supply_fail = 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_reset_n <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(13'h1ff8 + 13'(i), RST_IMG[8*i +: 8]);
		end
		// Plain memory, top of plain range included
		wr(13'h0000, 8'h5a);
		wr(13'h1ff7, 8'ha5);
		host_u.access(2'b10, 1'b0, 1'b0, 13'h0aaa, 8'h3c, q, seen);
		check("wr_oe", {7'h00, seen}, 8'h00);
		rd(13'h0aaa, 8'h3c);
		rd(13'h1ff7, 8'ha5);
		// Refused accesses leave memory alone
		quiet(2'b11, 1'b0, 1'b1);
		quiet(2'b11, 1'b1, 1'b0);
		quiet(2'b00, 1'b0, 1'b1);
		quiet(2'b00, 1'b1, 1'b0);
		quiet(2'b10, 1'b1, 1'b1);
		@(posedge i_clk_sys);
		i_supply_fail <= 1'b1;
		repeat (4) @(posedge i_clk_sys);
		quiet(2'b10, 1'b0, 1'b1);
		quiet(2'b10, 1'b1, 1'b0);
		i_supply_fail <= 1'b0;
		repeat (4) @(posedge i_clk_sys);
		rd(13'h0000, 8'h5a);
		// Spare control bits keep what was written
		wr(13'h1ff8, 8'h15);
		rd(13'h1ff8, 8'h15);
		wr(13'h1ff8, 8'h00);
		// Calendar roll from 23:59:59 at month ends and on 28 February of leap year 00
		for (int i = 0; i < 5; i++) begin
			set_time({CAL[i][47:24], 8'h07, 8'h23, 8'h59, 8'h59});
			repeat (6144) @(posedge i_clk_sys);
			wr(13'h1ff8, 8'h40);
			host_u.access(2'b10, 1'b1, 1'b0, 13'h1ff9, 8'h00, q, seen);
			check("sec", q & 8'hfe, 8'h00);
			expv = {CAL[i][23:0], 8'h01, 8'h00, 8'h00};
			for (int j = 0; j < 6; j++) begin
				rd(13'h1ffa + 13'(j), expv[8*j +: 8]);
			end
			wr(13'h1ff8, 8'h00);
		end
		// Freeze holds the view while counting goes on
		set_time(56'h00010101000010);
		wr(13'h1ff8, 8'h40);
		host_u.access(2'b10, 1'b1, 1'b0, 13'h1ff9, 8'h00, q, seen);
		s0 = q;
		check("drive0", {7'h00, seen}, 8'h01);
		check("sec0", s0 & 8'hfe, 8'h10);
		check("halt0", s0 & 8'h80, 8'h00);
		repeat (8192) @(posedge i_clk_sys);
		rd(13'h1ff9, s0);
		wr(13'h1ff8, 8'h00);
		repeat (20) @(posedge i_clk_sys);
		host_u.access(2'b10, 1'b1, 1'b0, 13'h1ff9, 8'h00, q, seen);
		check("sec2", q & 8'hfe, 8'h12);
		// Stopped oscillator: no tick, no test toggle; restarted, the toggle runs
		set_time(56'h00010101000080);
		wr(13'h1ffc, 8'h41);
		repeat (8192) @(posedge i_clk_sys);
		rd(13'h1ff9, 8'h80);
		host_u.hold_read(13'h1ff9, flips);
		check("flips0", 8'(flips), 8'h00);
		wr(13'h1ff9, 8'h00);
		host_u.hold_read(13'h1ff9, flips);
		check("flips", 8'(flips), 8'h08);
		wr(13'h1ffc, 8'h01);
		final_report();
	end
endmodule
